// *** src/diag_prot_pkg.sv ***
// How it works
// - not all channels hi-z: shorts tests only
// - diagnostic start accepted any time by software
// - default phases 20, 20, 100, 230 ms
// - extension bit makes short phases 80 ms
// - per-channel diagnostic results readable by software
// - tweeter mode: pin low while current over threshold
// - tweeter low pulse lasts one switching period minimum
// - average limit cuts pulse, channels keep playing
// - severe short: only that channel stops, 200-390 us
// - overcurrent sets fault pin and fault register
// - dc offset timed trigger, shutdown optional, default on
// - dc shutdown stops only offending channel, fault asserted
// - clip pin asserted while any channel at full duty
// - pin source: clip, warning, both, tweeter
// - after reset pin shows thermal warning
// - three warning levels, pin on first level
// - diagnostic forces hi-z after pop-free ramp
// - full level: all hi-z, four phases, all channels
// - faults go straight to hi-z, no ramp
// - thermal status bits 5 to 7 show levels
package diag_prot_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25; // system clock rate
	localparam int MS_CYCLES = CLK_MHZ * 1000; // cycles per ms
	localparam int OC_STOP_MIN_US = 200; // earliest overcurrent shutdown
	localparam int OC_STOP_MAX_US = 390; // latest overcurrent shutdown
	localparam int OC_STOP_CYCLES = OC_STOP_MIN_US * CLK_MHZ; // sustained peak before stop
	localparam int SW_CYCLES = 60; // one switching period in clocks
	localparam int T_SHORT_MS = 20; // short phase, default
	localparam int T_SHORT_EXT_MS = 80; // short phase, extended
	localparam int T_OPEN_MS = 100; // open-load phase
	localparam int T_SHORTED_MS = 230; // shorted-load phase
	localparam int T_RAMP_MS = 2; // pop-free ramp to hi-z

	// ----------------------------------------
	// register indices, byte address is index times four
	// ----------------------------------------
	localparam logic [5:0] IDX_FAULT = 6'h02; // fault record
	localparam logic [5:0] IDX_THERMAL = 6'h04; // thermal status
	localparam logic [5:0] IDX_DIAG_RES = 6'h05; // diagnostic results
	localparam logic [5:0] IDX_CLIP_CFG = 6'h0A; // pin source and dc setup
	localparam logic [5:0] IDX_CH_MODE = 6'h0C; // hi-z or play per channel
	localparam logic [5:0] IDX_DIAG_CTRL = 6'h10; // diagnostic control

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CFG_SEL_LSB = 0; // clip pin source, 2 bits
	localparam int CFG_DC_SD_DIS_BIT = 2; // 1 disables dc shutdown
	localparam int CFG_DC_TIME_LSB = 4; // dc trigger time in ms, 4 bits
	localparam logic [7:0] CLIP_CFG_RST = 8'h51; // warning source, 5 ms dc
	localparam int MODE_RESTART_LSB = 4; // write one: clear faults, restart
	localparam logic [3:0] MODE_HIZ_RST = 4'hF; // all channels hi-z
	localparam int DIAG_START_BIT = 0; // write one: start diagnostic
	localparam int DIAG_TWEET_BIT = 1; // tweeter detect mode
	localparam int DIAG_BUSY_BIT = 2; // read: sequencer running
	localparam int DIAG_FULL_BIT = 3; // read: current or last run at full level
	localparam int DIAG_EXT_BIT = 4; // extended short phases
	localparam int THERM_LSB = 5; // warning levels, bits 5 to 7

	// ----------------------------------------
	// enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_CLIP = 2'h0,
		SRC_WARN = 2'h1,
		SRC_BOTH = 2'h2,
		SRC_TWEETER = 2'h3
	} clip_src_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RAMP = 6'h02,
		ST_GND = 6'h04,
		ST_SUP = 6'h08,
		ST_OPEN = 6'h10,
		ST_LOADSH = 6'h20
	} diag_state_t;

endpackage

// *** src/load_diag_protection_ctrl.sv ***
`timescale 1ns/1ns
// load diagnostic and protection supervisor, four channels
module load_diag_protection_ctrl #(
	parameter int MS_CYCLES = diag_prot_pkg::MS_CYCLES,
	parameter int OC_STOP_CYCLES = diag_prot_pkg::OC_STOP_CYCLES,
	parameter int SW_CYCLES = diag_prot_pkg::SW_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] ocp_peak_in,
	input wire logic [3:0] avg_limit_in,
	input wire logic [3:0] dc_offset_in,
	input wire logic [3:0] full_duty_in,
	input wire logic [3:0] tweeter_over_in,
	input wire logic [2:0] temp_level_in,
	input wire logic [3:0] diag_gnd_in,
	input wire logic [3:0] diag_sup_in,
	input wire logic [3:0] diag_open_in,
	input wire logic [3:0] diag_shorted_in,
	input wire logic fault_pin_in,
	input wire logic clip_warn_pin_in,
	output logic fault_pin_out,
	output logic fault_pin_oe_n_out,
	output logic clip_warn_pin_out,
	output logic clip_warn_pin_oe_n_out,
	output logic [3:0] hiz_out,
	output logic [3:0] pulse_cut_out
);

	localparam int OCW = $clog2(OC_STOP_CYCLES + 1);
	localparam int SWW = $clog2(SW_CYCLES + 1);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic ms_tick; // one-ms enable
	logic acc_ff; // access phase, waitrequest low
	logic bus_wr; // write takes effect now
	logic [5:0] idx; // word index of access
	logic idx_ok; // address word aligned
	logic [7:0] clip_cfg_ff; // pin source and dc setup
	logic [3:0] hiz_req_ff; // software hi-z request
	logic diag_ext_ff; // extended short phases
	logic tweet_ff; // tweeter detect mode
	logic [3:0] oc_flt_ff; // overcurrent record
	logic [3:0] dc_flt_ff; // dc offset record
	logic [3:0] oc_hit; // overcurrent trigger now
	logic [3:0] dc_hit; // dc trigger now
	logic [3:0] restart; // host clear per channel
	logic [OCW-1:0] oc_cnt_ff [4]; // sustained peak clocks
	logic [3:0] dc_ms_ff [4]; // dc offset ms count
	diag_prot_pkg::diag_state_t st_ff; // sequencer state
	diag_prot_pkg::diag_state_t nxt_st; // next state
	logic full_ff; // full level in this run
	logic [7:0] ph_ms_ff; // ms in current phase
	logic [7:0] ph_len; // length of current phase
	logic ph_done; // phase ends this cycle
	logic start; // diagnostic start write
	logic [15:0] res_ff; // results, four bits per channel
	logic [SWW-1:0] tw_hold_ff; // tweeter low pulse stretch
	logic tw_prev_ff; // tweeter raw last cycle
	logic tw_raw; // tweeter current over threshold
	logic pin_clip; // clip source
	logic pin_warn; // warning source
	logic pin_tw; // tweeter source
	logic nxt_pin; // clip pin asserted next
	logic [3:0] dc_sd; // channels stopped by dc
	logic [31:0] nxt_rd; // read mux

	// ----------------------------------------
	// millisecond enable
	// ----------------------------------------
	tick_gen #(
		.CYCLES(MS_CYCLES)
	) u_ms (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_out(ms_tick)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	assign idx = avs_address[7:2];
	assign idx_ok = (avs_address[1:0] == 2'h0);
	assign bus_wr = avs_write & acc_ff & avs_byteenable[0] & idx_ok;

	// one wait state, then the access edge
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			acc_ff <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else if ((avs_read | avs_write) & ~acc_ff) begin
			acc_ff <= 1'b1;
			avs_waitrequest <= 1'b0;
		end else begin
			acc_ff <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
	end

	// read data captured with the wait state
	always_comb begin
		nxt_rd = 32'h0;
		if (idx_ok) begin
			unique case (idx)
				diag_prot_pkg::IDX_FAULT: nxt_rd[7:0] = {dc_flt_ff, oc_flt_ff};
				diag_prot_pkg::IDX_THERMAL: begin
					nxt_rd[diag_prot_pkg::THERM_LSB +: 3] = temp_level_in;
					nxt_rd[1:0] = {clip_warn_pin_in, fault_pin_in};
				end
				diag_prot_pkg::IDX_DIAG_RES: nxt_rd[15:0] = res_ff;
				diag_prot_pkg::IDX_CLIP_CFG: nxt_rd[7:0] = clip_cfg_ff;
				diag_prot_pkg::IDX_CH_MODE: nxt_rd[3:0] = hiz_req_ff;
				diag_prot_pkg::IDX_DIAG_CTRL: begin
					nxt_rd[diag_prot_pkg::DIAG_TWEET_BIT] = tweet_ff;
					nxt_rd[diag_prot_pkg::DIAG_BUSY_BIT] = (st_ff != diag_prot_pkg::ST_IDLE);
					nxt_rd[diag_prot_pkg::DIAG_FULL_BIT] = full_ff;
					nxt_rd[diag_prot_pkg::DIAG_EXT_BIT] = diag_ext_ff;
				end
				default: nxt_rd = 32'h0; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~acc_ff) begin
			avs_readdata <= nxt_rd;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			clip_cfg_ff <= diag_prot_pkg::CLIP_CFG_RST;
			hiz_req_ff <= diag_prot_pkg::MODE_HIZ_RST;
			diag_ext_ff <= 1'b0;
			tweet_ff <= 1'b0;
		end else if (bus_wr) begin
			if (idx == diag_prot_pkg::IDX_CLIP_CFG) begin
				clip_cfg_ff <= avs_writedata[7:0];
			end
			if (idx == diag_prot_pkg::IDX_CH_MODE) begin
				hiz_req_ff <= avs_writedata[3:0];
			end
			if (idx == diag_prot_pkg::IDX_DIAG_CTRL) begin
				diag_ext_ff <= avs_writedata[diag_prot_pkg::DIAG_EXT_BIT];
				tweet_ff <= avs_writedata[diag_prot_pkg::DIAG_TWEET_BIT];
			end
		end
	end

	// start and restart strobes, any state
	assign start = bus_wr & (idx == diag_prot_pkg::IDX_DIAG_CTRL)
		& avs_writedata[diag_prot_pkg::DIAG_START_BIT];
	assign restart = (bus_wr & (idx == diag_prot_pkg::IDX_CH_MODE))
		? avs_writedata[diag_prot_pkg::MODE_RESTART_LSB +: 4] : 4'h0;

	// ----------------------------------------
	// overcurrent shutdown
	// ----------------------------------------
	// peak must persist the minimum time
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			for (int i = 0; i < 4; i++) begin
				oc_cnt_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ocp_peak_in[i] & ~hiz_out[i] & ~oc_hit[i]) begin
					oc_cnt_ff[i] <= oc_cnt_ff[i] + 1'b1;
				end else begin
					oc_cnt_ff[i] <= '0; // released or stopped
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			oc_hit[i] = (oc_cnt_ff[i] == OCW'(OC_STOP_CYCLES - 1));
		end
	end

	// record holds until host restart; set wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			oc_flt_ff <= 4'h0;
		end else begin
			oc_flt_ff <= (oc_flt_ff & ~restart) | oc_hit;
		end
	end

	// ----------------------------------------
	// dc offset detection
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			for (int i = 0; i < 4; i++) begin
				dc_ms_ff[i] <= 4'h0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (~dc_offset_in[i] | dc_hit[i]) begin
					dc_ms_ff[i] <= 4'h0; // offset gone or triggered
				end else if (ms_tick) begin
					dc_ms_ff[i] <= dc_ms_ff[i] + 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// level held for programmed time
			dc_hit[i] = dc_offset_in[i]
				& (dc_ms_ff[i] == clip_cfg_ff[diag_prot_pkg::CFG_DC_TIME_LSB +: 4]);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dc_flt_ff <= 4'h0;
		end else begin
			dc_flt_ff <= (dc_flt_ff & ~restart) | dc_hit;
		end
	end

	// shutdown only when not disabled
	assign dc_sd = clip_cfg_ff[diag_prot_pkg::CFG_DC_SD_DIS_BIT] ? 4'h0 : dc_flt_ff;

	// ----------------------------------------
	// diagnostic sequencer
	// ----------------------------------------
	always_comb begin
		unique case (st_ff)
			diag_prot_pkg::ST_RAMP: ph_len = 8'(diag_prot_pkg::T_RAMP_MS);
			diag_prot_pkg::ST_GND,
			diag_prot_pkg::ST_SUP: ph_len = diag_ext_ff ? 8'(diag_prot_pkg::T_SHORT_EXT_MS)
				: 8'(diag_prot_pkg::T_SHORT_MS);
			diag_prot_pkg::ST_OPEN: ph_len = 8'(diag_prot_pkg::T_OPEN_MS);
			diag_prot_pkg::ST_LOADSH: ph_len = 8'(diag_prot_pkg::T_SHORTED_MS);
			default: ph_len = 8'h00;
		endcase
	end

	assign ph_done = ms_tick & (ph_ms_ff == ph_len - 8'h01);

	// phase order, reduced level ends after supply
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			diag_prot_pkg::ST_IDLE: nxt_st = st_ff;
			diag_prot_pkg::ST_RAMP: if (ph_done) nxt_st = diag_prot_pkg::ST_GND;
			diag_prot_pkg::ST_GND: if (ph_done) nxt_st = diag_prot_pkg::ST_SUP;
			diag_prot_pkg::ST_SUP: begin
				if (ph_done) begin
					nxt_st = full_ff ? diag_prot_pkg::ST_OPEN : diag_prot_pkg::ST_IDLE;
				end
			end
			diag_prot_pkg::ST_OPEN: if (ph_done) nxt_st = diag_prot_pkg::ST_LOADSH;
			diag_prot_pkg::ST_LOADSH: if (ph_done) nxt_st = diag_prot_pkg::ST_IDLE;
			default: nxt_st = diag_prot_pkg::ST_IDLE; // illegal code
		endcase
		if (start) begin
			nxt_st = diag_prot_pkg::ST_RAMP; // restart from ramp
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			st_ff <= diag_prot_pkg::ST_IDLE;
			ph_ms_ff <= 8'h00;
			full_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (start | ph_done) begin
				ph_ms_ff <= 8'h00; // new phase
			end else if (ms_tick) begin
				ph_ms_ff <= ph_ms_ff + 8'h01;
			end
			if (start) begin
				full_ff <= &hiz_req_ff;
			end
		end
	end

	// results sampled at each test phase end, not after the ramp
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			res_ff <= 16'h0000;
		end else if (start) begin
			res_ff <= 16'h0000;
		end else if (ph_done) begin
			for (int i = 0; i < 4; i++) begin
				unique case (st_ff)
					diag_prot_pkg::ST_GND: res_ff[i*4] <= diag_gnd_in[i];
					diag_prot_pkg::ST_SUP: res_ff[i*4+1] <= diag_sup_in[i];
					diag_prot_pkg::ST_OPEN: res_ff[i*4+2] <= diag_open_in[i];
					diag_prot_pkg::ST_LOADSH: res_ff[i*4+3] <= diag_shorted_in[i];
					default: res_ff[i*4] <= res_ff[i*4]; // ramp holds
				endcase
			end
		end
	end

	// ----------------------------------------
	// power stage control
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hiz_out <= diag_prot_pkg::MODE_HIZ_RST;
			pulse_cut_out <= 4'h0;
		end else begin
			// faults stop at once, test waits for ramp
			hiz_out <= hiz_req_ff | oc_flt_ff | oc_hit | dc_sd
				| ((nxt_st != diag_prot_pkg::ST_IDLE && nxt_st != diag_prot_pkg::ST_RAMP)
				? 4'hF : 4'h0);
			pulse_cut_out <= avg_limit_in & ~hiz_out;
		end
	end

	// ----------------------------------------
	// fault pin, open drain active low
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			fault_pin_out <= 1'b0;
			fault_pin_oe_n_out <= 1'b1;
		end else begin
			fault_pin_out <= 1'b0;
			fault_pin_oe_n_out <= ~(|(oc_flt_ff | dc_sd));
		end
	end

	// ----------------------------------------
	// clip and warning pin
	// ----------------------------------------
	assign tw_raw = |(tweeter_over_in & ~hiz_out);
	assign pin_clip = |full_duty_in;
	assign pin_warn = temp_level_in[0];
	assign pin_tw = tweet_ff & (tw_raw | (tw_hold_ff != '0));

	// stretch each tweeter low pulse
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tw_hold_ff <= '0;
			tw_prev_ff <= 1'b0;
		end else begin
			tw_prev_ff <= tw_raw;
			if (tw_raw & ~tw_prev_ff) begin
				tw_hold_ff <= SWW'(SW_CYCLES - 1);
			end else if (tw_hold_ff != '0) begin
				tw_hold_ff <= tw_hold_ff - 1'b1;
			end
		end
	end

	always_comb begin
		unique case (diag_prot_pkg::clip_src_t'(clip_cfg_ff[diag_prot_pkg::CFG_SEL_LSB +: 2]))
			diag_prot_pkg::SRC_CLIP: nxt_pin = pin_clip;
			diag_prot_pkg::SRC_WARN: nxt_pin = pin_warn;
			diag_prot_pkg::SRC_BOTH: nxt_pin = pin_clip | pin_warn;
			diag_prot_pkg::SRC_TWEETER: nxt_pin = pin_tw;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			clip_warn_pin_out <= 1'b0;
			clip_warn_pin_oe_n_out <= 1'b1;
		end else begin
			clip_warn_pin_out <= 1'b0;
			clip_warn_pin_oe_n_out <= ~nxt_pin;
		end
	end

endmodule // load_diag_protection_ctrl

// *** src/tick_gen.sv ***
`timescale 1ns/1ns
// one-cycle enable every CYCLES clocks
module tick_gen #(
	parameter int CYCLES = 25000
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	output logic tick_out
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_ff; // cycles since last tick

	// ----------------------------------------
	// divider
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
			tick_out <= 1'b0;
		end else if (cnt_ff == CW'(CYCLES - 1)) begin
			// wrap and pulse
			cnt_ff <= '0;
			tick_out <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
			tick_out <= 1'b0;
		end
	end

endmodule // tick_gen

// *** verif/diag_prot_monitor.sv ***
`timescale 1ns/1ns
// -----
// port checker for the supervisor
// -----
module diag_prot_monitor #(
	parameter int OC_STOP_CYCLES = 20
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [3:0] ocp_peak_in,
	input wire logic [3:0] avg_limit_in,
	input wire logic [3:0] full_duty_in,
	input wire logic [3:0] tweeter_over_in,
	input wire logic [2:0] temp_level_in,
	input wire logic fault_pin_oe_n_out,
	input wire logic clip_warn_pin_oe_n_out,
	input wire logic [3:0] hiz_out,
	input wire logic [3:0] pulse_cut_out
);
	logic [15:0] ocp_run_ff; // cycles of peak current on playing channel 0
	// counts an unbroken peak on channel 0
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !ocp_peak_in[0] || hiz_out[0]) ocp_run_ff <= 16'h0;
		else if (ocp_run_ff != 16'hFFFF) ocp_run_ff <= ocp_run_ff + 16'h1;
	end
	default clocking mon_cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	reset_outputs_a: assert property ($fell(rst_in) |-> hiz_out == 4'hF && pulse_cut_out == 4'h0
		&& fault_pin_oe_n_out && clip_warn_pin_oe_n_out) else $error("outputs not at reset values");
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait state not one cycle");
	wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
	read_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data changed without read");
	pulse_cut_a: assert property (avg_limit_in != 4'h0 |=> pulse_cut_out == ($past(avg_limit_in) & $past(hiz_out))
		^ $past(avg_limit_in)) else $error("pulse cut does not follow limit");
	ocp_stop_a: assert property (ocp_run_ff == 16'(OC_STOP_CYCLES) |-> ##[0:3] hiz_out[0])
		else $error("channel not stopped on sustained peak");
	ocp_fault_a: assert property (ocp_run_ff == 16'(OC_STOP_CYCLES) |-> ##[1:4] !fault_pin_oe_n_out)
		else $error("fault pin not asserted on shutdown");
	clip_release_a: assert property ((full_duty_in == 4'h0 && temp_level_in == 3'h0 && tweeter_over_in == 4'h0) [*8]
		|-> clip_warn_pin_oe_n_out) else $error("clip pin held without source");
	tweet_width_a: assert property ($fell(clip_warn_pin_oe_n_out) && full_duty_in == 4'h0 && temp_level_in == 3'h0
		&& $past(full_duty_in) == 4'h0 && $past(temp_level_in) == 3'h0 |-> !clip_warn_pin_oe_n_out [*3])
		else $error("tweeter pulse too short");
	diag_hiz_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h40 && avs_byteenable[0]
		&& avs_writedata[0] |-> ##[105:300] hiz_out == 4'hF) else $error("diagnostic did not force hi-z");
endmodule // diag_prot_monitor

// *** verif/host_master.sv ***
`timescale 1ns/1ns
// -----
// system processor model on the register bus
// -----
module host_master (
	input wire logic clk_sys_in,
	output logic [7:0] avs_address_out,
	output logic avs_read_out,
	output logic avs_write_out,
	output logic [31:0] avs_writedata_out,
	output logic [3:0] avs_byteenable_out,
	input wire logic [31:0] avs_readdata_in,
	input wire logic avs_waitrequest_in
);
	initial begin
		avs_address_out = 8'h0;
		avs_read_out = 1'b0;
		avs_write_out = 1'b0;
		avs_writedata_out = 32'h0;
		avs_byteenable_out = 4'hF;
	end
	// one access, held until waitrequest is sampled low at a rising edge
	task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] wdata, output logic [31:0] rdata);
		@(posedge clk_sys_in);
		avs_address_out <= addr;
		avs_writedata_out <= {24'h0, wdata};
		avs_write_out <= wr;
		avs_read_out <= !wr;
		// no cycle count assumed, the bench watchdog ends a hang
		do begin
			@(posedge clk_sys_in);
		end while (avs_waitrequest_in !== 1'b0);
		// data taken at the completing edge, then release
		rdata = avs_readdata_in;
		avs_read_out <= 1'b0;
		avs_write_out <= 1'b0;
		// released lines show no stale value
		avs_address_out <= ~addr;
		avs_writedata_out <= ~{24'h0, wdata};
	endtask
endmodule // host_master

// *** verif/load_diag_protection_ctrl_tb.sv ***
`timescale 1ns/1ns
module load_diag_protection_ctrl_tb;
	localparam int OC_STOP_CYCLES = 20; // shortened shutdown count
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] address;
	logic read, write, waitreq;
	logic [31:0] wdata, rdata;
	logic [3:0] ben, hiz, cut;
	logic [3:0] ocp = 4'h0, avg = 4'h0, dc = 4'h0, full = 4'h0, tweet = 4'h0;
	logic [3:0] dg = 4'h1, ds = 4'h2, dop = 4'h4, dsh = 4'h8; // comparator results per channel
	logic [2:0] temp = 3'h0;
	logic f_out, f_oe_n, c_out, c_oe_n;
	wire fault_pin = f_oe_n ? 1'b1 : f_out; // pulled-up open drain
	wire clip_pin = c_oe_n ? 1'b1 : c_out;
	int mismatches = 0, comparisons = 0, cyc = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) cyc <= cyc + 1;
	load_diag_protection_ctrl #(.MS_CYCLES(50), .OC_STOP_CYCLES(OC_STOP_CYCLES), .SW_CYCLES(4)) load_diag_protection_ctrl_inst (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address(address), .avs_read(read), .avs_write(write),
		.avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata), .avs_waitrequest(waitreq),
		.ocp_peak_in(ocp), .avg_limit_in(avg), .dc_offset_in(dc), .full_duty_in(full), .tweeter_over_in(tweet),
		.temp_level_in(temp), .diag_gnd_in(dg), .diag_sup_in(ds), .diag_open_in(dop), .diag_shorted_in(dsh),
		.fault_pin_in(fault_pin), .clip_warn_pin_in(clip_pin), .fault_pin_out(f_out), .fault_pin_oe_n_out(f_oe_n),
		.clip_warn_pin_out(c_out), .clip_warn_pin_oe_n_out(c_oe_n), .hiz_out(hiz), .pulse_cut_out(cut));
	host_master host_master_inst (.clk_sys_in(clk_sys_in), .avs_address_out(address), .avs_read_out(read),
		.avs_write_out(write), .avs_writedata_out(wdata), .avs_byteenable_out(ben), .avs_readdata_in(rdata),
		.avs_waitrequest_in(waitreq));
	// -----
	// shared tasks
	// -----
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		host_master_inst.access(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		host_master_inst.access(a, 1'b0, 8'h0, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string name);
		logic [31:0] d;
		rd(a, d);
		check(name, d, e);
	endtask
	// -----
	// scenarios
	// -----
	task automatic t_reset();
		chk_rd(8'h28, 32'h51, "clip_cfg");
		chk_rd(8'h30, 32'h0F, "mode");
		chk_rd(8'h3C, 32'h0, "unmapped");
		chk_rd(8'h29, 32'h0, "misaligned");
		wr(8'h08, 8'hFF);
		chk_rd(8'h08, 32'h0, "fault_ro");
		check("clip_idle", clip_pin, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_thermal();
		@(posedge clk_sys_in) temp <= 3'h1;
		wait_n(3);
		check("warn_first", clip_pin, 1'b0);
		@(posedge clk_sys_in) temp <= 3'h7;
		chk_rd(8'h10, 32'hE1, "thermal");
		@(posedge clk_sys_in) temp <= 3'h0;
		$display("test thermal done");
	endtask
	task automatic t_clip();
		for (int s = 0; s < 3; s++) begin
			wr(8'h28, 8'h50 | 8'(s));
			@(posedge clk_sys_in) temp <= 3'h1;
			wait_n(3);
			check("warn_src", clip_pin, s == 0);
			@(posedge clk_sys_in) begin temp <= 3'h0; full <= 4'h8; end
			wait_n(3);
			check("clip_src", clip_pin, s == 1);
			@(posedge clk_sys_in) full <= 4'h0;
			wait_n(3);
			check("clip_off", clip_pin, 1'b1);
		end
		$display("test clip done");
	endtask
	task automatic t_pulse();
		wr(8'h30, 8'h00);
		@(posedge clk_sys_in) avg <= 4'h3;
		wait_n(3);
		check("pulse_cut", cut, 4'h3);
		check("still_play", hiz, 4'h0);
		@(posedge clk_sys_in) avg <= 4'h0;
		$display("test pulse done");
	endtask
	task automatic t_ocp();
		@(posedge clk_sys_in) ocp <= 4'h1;
		wait_n(OC_STOP_CYCLES - 5);
		@(posedge clk_sys_in) ocp <= 4'h0;
		wait_n(3);
		check("peak_brief", hiz, 4'h0);
		@(posedge clk_sys_in) ocp <= 4'h1;
		wait_n(OC_STOP_CYCLES + 4);
		check("ocp_hiz", hiz, 4'h1);
		check("ocp_fault", fault_pin, 1'b0);
		@(posedge clk_sys_in) ocp <= 4'h0;
		chk_rd(8'h08, 32'h01, "ocp_rec");
		check("ocp_held", hiz, 4'h1);
		wr(8'h30, 8'h10);
		chk_rd(8'h08, 32'h0, "ocp_clr");
		wait_n(2);
		check("restart", {fault_pin, hiz}, 5'h10);
		$display("test overcurrent done");
	endtask
	task automatic t_dc();
		wr(8'h28, 8'h21);
		@(posedge clk_sys_in) dc <= 4'h4;
		wait_n(40);
		check("dc_early", hiz, 4'h0);
		wait_n(70);
		check("dc_stop", {fault_pin, hiz}, 5'h04);
		@(posedge clk_sys_in) dc <= 4'h0;
		chk_rd(8'h08, 32'h40, "dc_rec");
		wr(8'h30, 8'h40);
		wr(8'h28, 8'h05);
		@(posedge clk_sys_in) dc <= 4'h2;
		wait_n(4);
		check("dc_nostop", {fault_pin, hiz}, 5'h10);
		@(posedge clk_sys_in) dc <= 4'h0;
		chk_rd(8'h08, 32'h20, "dc_rec_off");
		wr(8'h30, 8'h20);
		wr(8'h28, 8'h51);
		$display("test dc offset done");
	endtask
	task automatic t_tweet();
		wr(8'h40, 8'h02); // host starts tweeter mode, one channel at a time
		wr(8'h28, 8'h53); // pin reports tweeter
		wr(8'h30, 8'h0E); // channel 0 into play after activation
		@(posedge clk_sys_in) tweet <= 4'h1;
		@(posedge clk_sys_in) tweet <= 4'h0;
		wait_n(3);
		check("tweet_min", clip_pin, 1'b0);
		wait_n(7);
		check("tweet_end", clip_pin, 1'b1);
		@(posedge clk_sys_in) tweet <= 4'h1;
		wait_n(12);
		check("tweet_hold", clip_pin, 1'b0);
		@(posedge clk_sys_in) tweet <= 4'h2;
		wait_n(10);
		check("tweet_hiz", clip_pin, 1'b1);
		@(posedge clk_sys_in) tweet <= 4'h0;
		wr(8'h40, 8'h00);
		wr(8'h28, 8'h51);
		$display("test tweeter done");
	endtask
	task automatic run_diag(input logic [7:0] mode, input logic [7:0] ctl, input logic [31:0] first,
		input int lo, input int hi, input logic [31:0] res);
		int t0;
		int n;
		logic [31:0] d;
		wr(8'h30, mode);
		t0 = cyc;
		wr(8'h40, ctl);
		chk_rd(8'h40, first, "diag_level");
		n = 0;
		do begin
			rd(8'h40, d);
			n++;
		end while (d[2] === 1'b1 && n < 20000);
		check("diag_time", (cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1);
		chk_rd(8'h14, res, "diag_res");
		$display("test diagnostic done");
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		t_reset();
		t_thermal();
		t_clip();
		t_pulse();
		t_ocp();
		t_dc();
		t_tweet();
		run_diag(8'h0F, 8'h01, 32'h0C, 18300, 18650, 32'h8421);
		run_diag(8'h0E, 8'h11, 32'h14, 7900, 8150, 32'h0021); // host extends shorts for heavy load
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		mismatches++;
		$display("watchdog expired");
		complete_run();
	end
endmodule // load_diag_protection_ctrl_tb
bind load_diag_protection_ctrl diag_prot_monitor #(.OC_STOP_CYCLES(OC_STOP_CYCLES)) mon_inst (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ocp_peak_in(ocp_peak_in),
	.avg_limit_in(avg_limit_in), .full_duty_in(full_duty_in), .tweeter_over_in(tweeter_over_in),
	.temp_level_in(temp_level_in), .fault_pin_oe_n_out(fault_pin_oe_n_out),
	.clip_warn_pin_oe_n_out(clip_warn_pin_oe_n_out), .hiz_out(hiz_out), .pulse_cut_out(pulse_cut_out));
